// [nvm_access_pkg.sv]
// constants and types for the data nvm cpu access block
package nvm_access_pkg;
    // i/o offsets of the access registers
    localparam logic [5:0] OFS_CONTROL = 6'h1f;
    localparam logic [5:0] OFS_DATA = 6'h20;
    localparam logic [5:0] OFS_ADDR_LOW = 6'h21;
    localparam logic [5:0] OFS_ADDR_HIGH = 6'h22;
    // data space sees i/o space shifted by this amount
    localparam logic [7:0] DATA_SPACE_BASE = 8'h20;
    localparam logic [7:0] DATA_SPACE_TOP = 8'h5f;
    // only this low part of i/o space takes single bit operations
    localparam logic [5:0] BIT_OP_TOP = 6'h1f;
    // control register field positions
    localparam int CTL_READ = 0;
    localparam int CTL_PROG = 1;
    localparam int CTL_ARM = 2;
    localparam int CTL_RIE = 3;
    localparam int CTL_MODE_LO = 4;
    localparam int CTL_MODE_HI = 5;
    // array geometry
    localparam int ADDR_W = 12;
    localparam int DEPTH = 4096;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [7:0] FULL_MASK = 8'hff;
    // programming modes
    localparam logic [1:0] MODE_ERASE_WRITE = 2'h0;
    localparam logic [1:0] MODE_ERASE = 2'h1;
    localparam logic [1:0] MODE_WRITE = 2'h2;
    localparam logic [1:0] MODE_RESERVED = 2'h3;
    // timing
    localparam int CLK_MHZ = 50;
    localparam int TIME_ERASE_WRITE_US = 3400;
    localparam int TIME_SINGLE_US = 1800;
    localparam int ERASE_WRITE_CYCLES = TIME_ERASE_WRITE_US * CLK_MHZ;
    localparam int SINGLE_CYCLES = TIME_SINGLE_US * CLK_MHZ;
    localparam int PROG_CNT_W = 18;
    localparam logic [2:0] READ_STALL = 3'h4;
    localparam logic [2:0] WRITE_STALL = 3'h2;
    localparam logic [2:0] ARM_WINDOW = 3'h4;

    // one i/o access from the core
    typedef struct packed {
        logic [7:0] addr;
        logic data_space;
        logic wr;
        logic rd;
        logic bit_set;
        logic bit_clr;
        logic [2:0] bit_sel;
        logic [7:0] wdata;
    } io_req_t;

    // read answer to the core
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } io_rsp_t;
endpackage

// [nvm_access.sv]
// cpu access controller for the on-chip data nvm array
`timescale 1ns/10ps
`default_nettype none

module nvm_access
    import nvm_access_pkg::*;
#(
    parameter int ERASE_WRITE_CYC = nvm_access_pkg::ERASE_WRITE_CYCLES,
    parameter int SINGLE_CYC = nvm_access_pkg::SINGLE_CYCLES
)(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // core i/o access
    input wire nvm_access_pkg::io_req_t io_req,
    output nvm_access_pkg::io_rsp_t io_rsp,
    output logic cpu_stall,
    // interrupt
    input wire logic global_irq_enable,
    output logic ready_irq
);
    import nvm_access_pkg::*;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0] data;
        logic [1:0] mode;
        logic rie;
        logic [2:0] arm_cnt;
        logic prog;
        logic [1:0] op_mode;
        logic [7:0] op_data;
        logic [PROG_CNT_W-1:0] prog_cnt;
        logic [2:0] stall_cnt;
        io_rsp_t rsp;
    } state_t;

    state_t st_ff;
    state_t nxt_st;
    logic [7:0] mem [0:DEPTH-1];
    logic [6:0] dec;
    logic hit;
    logic [5:0] idx;
    logic [7:0] wmask;
    logic [7:0] wval;
    logic do_wr;
    logic prog_done;

    ////////////////////////////////////////////////////////////////////
    // decoding

    // returns {hit, i/o index}; data space is i/o space shifted up
    function automatic logic [6:0] io_decode(input io_req_t r);
        logic [7:0] a;
        a = r.addr - DATA_SPACE_BASE;
        if (r.data_space)
            io_decode = {(r.addr >= DATA_SPACE_BASE) &&
                         (r.addr <= DATA_SPACE_TOP), a[5:0]};
        else
            io_decode = {r.addr[7:6] == 2'h0, r.addr[5:0]};
    endfunction

    // control byte as the core sees it; read strobe never stored
    function automatic logic [7:0] ctl_view(input state_t s);
        logic [7:0] v;
        v = ZERO_BYTE;
        v[CTL_MODE_HI] = s.mode[1];
        v[CTL_MODE_LO] = s.mode[0];
        v[CTL_RIE] = s.rie;
        v[CTL_ARM] = s.arm_cnt != 3'h0;
        v[CTL_PROG] = s.prog;
        ctl_view = v;
    endfunction

    assign dec = io_decode(io_req);
    assign hit = dec[6];
    assign idx = dec[5:0];

    always_comb
    begin
        wmask = FULL_MASK;
        wval = io_req.wdata;
        do_wr = hit && io_req.wr;
        if ((io_req.bit_set || io_req.bit_clr) && hit &&
            !io_req.data_space && idx <= BIT_OP_TOP)
        begin
            wmask = 8'h01 << io_req.bit_sel;
            wval = io_req.bit_set ? wmask : ZERO_BYTE;
            do_wr = 1'b1;
        end
    end

    assign prog_done = st_ff.prog && st_ff.prog_cnt == '0;

    ////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.rsp.valid = 1'b0;
        if (st_ff.arm_cnt != 3'h0)
            nxt_st.arm_cnt = st_ff.arm_cnt - 3'h1;
        if (st_ff.stall_cnt != 3'h0)
            nxt_st.stall_cnt = st_ff.stall_cnt - 3'h1;
        if (st_ff.prog && st_ff.prog_cnt != '0)
            nxt_st.prog_cnt = st_ff.prog_cnt - 1'b1;
        if (prog_done)
            nxt_st.prog = 1'b0;

        if (hit && io_req.rd)
        begin
            nxt_st.rsp.valid = 1'b1;
            unique case (idx)
                OFS_CONTROL: nxt_st.rsp.data = ctl_view(st_ff);
                OFS_DATA: nxt_st.rsp.data = st_ff.data;
                OFS_ADDR_LOW: nxt_st.rsp.data = st_ff.addr[7:0];
                OFS_ADDR_HIGH: nxt_st.rsp.data = {4'h0, st_ff.addr[11:8]};
                default: nxt_st.rsp.data = ZERO_BYTE;
            endcase
        end

        if (do_wr)
        begin
            unique case (idx)
                OFS_DATA:
                    nxt_st.data = (st_ff.data & ~wmask) | (wval & wmask);
                OFS_ADDR_LOW:
                    if (!st_ff.prog)
                        nxt_st.addr[7:0] = (st_ff.addr[7:0] & ~wmask) |
                                           (wval & wmask);
                OFS_ADDR_HIGH:
                    if (!st_ff.prog)
                        nxt_st.addr[11:8] = (st_ff.addr[11:8] & ~wmask[3:0])
                                            | (wval[3:0] & wmask[3:0]);
                OFS_CONTROL:
                begin
                    if (wmask[CTL_RIE])
                        nxt_st.rie = wval[CTL_RIE];
                    if (!st_ff.prog && wmask[CTL_MODE_LO])
                        nxt_st.mode[0] = wval[CTL_MODE_LO];
                    if (!st_ff.prog && wmask[CTL_MODE_HI])
                        nxt_st.mode[1] = wval[CTL_MODE_HI];
                    if (wmask[CTL_ARM] && wval[CTL_ARM])
                        nxt_st.arm_cnt = ARM_WINDOW;
                    // strobe inside window; reserved mode refused
                    if (wmask[CTL_PROG] && wval[CTL_PROG] && !st_ff.prog &&
                        st_ff.arm_cnt != 3'h0 && st_ff.mode != MODE_RESERVED)
                    begin
                        nxt_st.prog = 1'b1;
                        nxt_st.op_mode = st_ff.mode;
                        nxt_st.op_data = st_ff.data;
                        nxt_st.prog_cnt = (st_ff.mode == MODE_ERASE_WRITE) ?
                            PROG_CNT_W'(ERASE_WRITE_CYC - 1) :
                            PROG_CNT_W'(SINGLE_CYC - 1);
                        nxt_st.arm_cnt = 3'h0;
                        nxt_st.stall_cnt = WRITE_STALL;
                    end
                    if (wmask[CTL_READ] && wval[CTL_READ] && !st_ff.prog)
                    begin
                        nxt_st.data = mem[st_ff.addr];
                        nxt_st.stall_cnt = READ_STALL;
                    end
                end
                default:
                    nxt_st.data = nxt_st.data;
            endcase
        end

        // busy write kept; mode kept while busy
        if (sys_rst)
        begin
            nxt_st.rie = 1'b0;
            nxt_st.arm_cnt = 3'h0;
            nxt_st.stall_cnt = 3'h0;
            nxt_st.rsp = '0;
            // test the flag itself, not its inverse: an unknown flag at
            // power up must fall through to the clearing branch
            if (st_ff.prog)
            begin
                nxt_st.op_mode = st_ff.op_mode;
            end
            else
            begin
                nxt_st.addr = '0;
                nxt_st.data = ZERO_BYTE;
                nxt_st.mode = MODE_ERASE_WRITE;
                nxt_st.op_mode = MODE_ERASE_WRITE;
                nxt_st.op_data = ZERO_BYTE;
                nxt_st.prog_cnt = '0;
                nxt_st.prog = 1'b0;
            end
        end
    end

    always_ff @(posedge clk)
        st_ff <= nxt_st;

    ////////////////////////////////////////////////////////////////////
    // storage array

    // byte array; erase leaves all ones, write only clears bits
    always_ff @(posedge clk)
    begin
        if (prog_done)
        begin
            unique case (st_ff.op_mode)
                MODE_ERASE_WRITE: mem[st_ff.addr] <= st_ff.op_data;
                MODE_ERASE: mem[st_ff.addr] <= ERASED_BYTE;
                MODE_WRITE: mem[st_ff.addr] <= mem[st_ff.addr] & st_ff.op_data;
                default: mem[st_ff.addr] <= mem[st_ff.addr];
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs

    assign io_rsp = st_ff.rsp;
    assign cpu_stall = st_ff.stall_cnt != 3'h0;
    assign ready_irq = st_ff.rie && global_irq_enable && !st_ff.prog;

    ////////////////////////////////////////////////////////////////////
    // checks

    // a strobe taken inside the window ends it early
    AST_ARM_TIMEOUT: assert property (@(posedge clk)
        disable iff (sys_rst)
        $rose(st_ff.arm_cnt == ARM_WINDOW)
        |-> ##3 (st_ff.prog || st_ff.arm_cnt == 3'h1)
        ##1 (st_ff.arm_cnt == 3'h0))
        else $error("arm window not four cycles");

    AST_READ_STALL: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(st_ff.stall_cnt == READ_STALL) |-> cpu_stall [*4] ##1 !cpu_stall)
        else $error("read stall not four cycles");

    AST_WRITE_STALL: assert property (@(posedge clk)
        disable iff (sys_rst)
        $rose(st_ff.prog) |-> cpu_stall [*2] ##1 !cpu_stall)
        else $error("write stall not two cycles");

    AST_MODE_HELD: assert property (@(posedge clk)
        st_ff.prog |=> $stable(st_ff.mode))
        else $error("mode changed while busy");

    AST_NO_RESERVED: assert property (@(posedge clk)
        $rose(st_ff.prog) |-> st_ff.op_mode != MODE_RESERVED)
        else $error("programming started in reserved mode");

    // the count is unknown before the first reset edge
    AST_DONE_ON_COUNT: assert property (@(posedge clk)
        disable iff (sys_rst)
        $fell(st_ff.prog) |-> $past(st_ff.prog_cnt) == '0)
        else $error("strobe cleared before time elapsed");

    AST_RESET_KEEPS: assert property (@(posedge clk)
        sys_rst && st_ff.prog && st_ff.prog_cnt != '0 |=> st_ff.prog)
        else $error("reset aborted a write");

    AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (sys_rst)
        st_ff.rie && global_irq_enable |-> ready_irq == !st_ff.prog)
        else $error("ready interrupt wrong");

    AST_ADDR_FROZEN: assert property (@(posedge clk)
        st_ff.prog && !sys_rst |=> $stable(st_ff.addr))
        else $error("address changed while busy");

    AST_HIGH_ZERO: assert property (@(posedge clk) disable iff (sys_rst)
        io_rsp.valid && $past(idx) == OFS_ADDR_HIGH && $past(hit)
        |-> io_rsp.data[7:4] == 4'h0)
        else $error("reserved address bits not zero");
endmodule

`default_nettype wire

// [nvm_core_model.sv]
// core model issuing i/o accesses to the nvm access block
`timescale 1ns/10ps
`default_nettype none
module nvm_core_model (
    // clock
    input wire logic clk,
    // block side
    input wire nvm_access_pkg::io_rsp_t io_rsp,
    input wire logic cpu_stall,
    output var nvm_access_pkg::io_req_t io_req
);
    import nvm_access_pkg::*;
    int stall_n;
    logic [7:0] rdata;
    initial io_req = '0;
    ////////////////////////////////////////////////////////////////////////
    // one access, set and released on falling edges
    task automatic acc(input logic [7:0] a, input logic [3:0] op,
        input logic [2:0] sel, input logic [7:0] d, input logic ds);
        io_req = '{a, ds, op[3], op[2], op[1], op[0], sel, d};
        @(negedge clk);
        io_req = '0;
        // a missing valid pulse shows up as an unknown byte
        rdata = io_rsp.valid ? io_rsp.data : 8'hxx;
        stall_n = 0;
        // the core sits out every stall before its next access
        while (cpu_stall && stall_n < 50)
        begin
            @(negedge clk);
            stall_n++;
        end
        // with no stall an idle edge keeps the next request apart
        if (stall_n == 50)
        begin
            nvm_access_tb_top.err_count++;
            nvm_access_tb_top.close_out();
        end
        else if (stall_n == 0)
            @(negedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        acc(a, 4'h8, 3'h0, d, 1'b0);
    endtask
    task automatic rd(input logic [7:0] a);
        acc(a, 4'h4, 3'h0, 8'h00, 1'b0);
    endtask
    task automatic bs(input logic [2:0] s);
        acc({2'h0, OFS_CONTROL}, 4'h2, s, 8'h00, 1'b0);
    endtask
    task automatic bc(input logic [2:0] s);
        acc({2'h0, OFS_CONTROL}, 4'h1, s, 8'h00, 1'b0);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // address first, arm, strobe
    task automatic prog(input logic [11:0] a, input logic [7:0] d,
        input logic [1:0] m);
        wr({2'h0, OFS_ADDR_HIGH}, {4'h0, a[11:8]});
        wr({2'h0, OFS_ADDR_LOW}, a[7:0]);
        wr({2'h0, OFS_DATA}, d);
        wr({2'h0, OFS_CONTROL}, {2'h0, m, 4'h8});
        bs(3'(CTL_ARM));
        bs(3'(CTL_PROG));
    endtask
endmodule
`default_nettype wire

// [nvm_access_tb_top.sv]
// self-checking bench for the nvm cpu access block
`timescale 1ns/10ps
`default_nettype none
module nvm_access_tb_top;
    import nvm_access_pkg::*;
    // short self-timed counts keep the run small
    localparam int EW = 40;
    localparam int SG = 20;
    localparam logic [7:0] CT = {2'h0, OFS_CONTROL};
    logic clk = 1'b0;
    logic sys_rst;
    logic gie;
    io_req_t io_req;
    io_rsp_t io_rsp;
    logic cpu_stall;
    logic ready_irq;
    int err_count = 0;
    int checked = 0;
    always #10 clk = ~clk;
    nvm_access #(.ERASE_WRITE_CYC(EW), .SINGLE_CYC(SG)) dut (.clk(clk),
        .sys_rst(sys_rst), .io_req(io_req), .io_rsp(io_rsp),
        .cpu_stall(cpu_stall), .global_irq_enable(gie),
        .ready_irq(ready_irq));
    nvm_core_model core (.clk(clk), .io_rsp(io_rsp), .cpu_stall(cpu_stall),
        .io_req(io_req));
    ////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("mismatches %0d checks %0d", err_count, checked);
        if (err_count == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        core.rd(a);
        chk(core.rdata, exp);
    endtask
    task automatic pulse_rst();
        sys_rst = 1'b1;
        @(negedge clk);
        sys_rst = 1'b0;
    endtask
    // ready level rises when the strobe drops; bounded wait
    task automatic wait_done(input int lo, input int hi);
        int n;
        n = 0;
        while (ready_irq !== 1'b1 && n <= hi)
        begin
            @(negedge clk);
            n++;
        end
        if (n > hi)
        begin
            err_count++;
            close_out();
        end
        else
            chk({7'h0, n >= lo}, 8'h01);
    endtask
    task automatic rd_byte(input logic [11:0] a, input logic [7:0] exp);
        core.wr({2'h0, OFS_ADDR_HIGH}, {4'h0, a[11:8]});
        core.wr({2'h0, OFS_ADDR_LOW}, a[7:0]);
        core.bs(3'(CTL_READ));
        chk(8'(core.stall_n), {5'h0, READ_STALL});
        rchk({2'h0, OFS_DATA}, exp);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic s_regs();
        rchk(CT, 8'h00);
        core.wr({2'h0, OFS_ADDR_HIGH}, 8'hff);
        rchk({2'h0, OFS_ADDR_HIGH}, 8'h0f);
        core.wr({2'h0, OFS_ADDR_LOW}, 8'ha5);
        core.acc(DATA_SPACE_BASE + 8'h21, 4'h4, 3'h0, 8'h00, 1'b1);
        chk(core.rdata, 8'ha5);
        core.wr(CT, 8'hc0);
        rchk(CT, 8'h00);
        core.bs(3'(CTL_RIE));
        core.bs(3'(CTL_MODE_LO));
        rchk(CT, 8'h18);
        core.bc(3'(CTL_RIE));
        rchk(CT, 8'h10);
        pulse_rst();
        rchk(CT, 8'h00);
    endtask
    task automatic s_modes();
        core.prog(12'h5a3, 8'h3c, MODE_ERASE_WRITE);
        chk(8'(core.stall_n), {5'h0, WRITE_STALL});
        wait_done(EW - 4, EW);
        rd_byte(12'h5a3, 8'h3c);
        rchk(CT, 8'h08);
        core.prog(12'h5a3, 8'h00, MODE_ERASE);
        wait_done(SG - 4, SG);
        rd_byte(12'h5a3, ERASED_BYTE);
        core.prog(12'h5a3, 8'h96, MODE_WRITE);
        wait_done(SG - 4, SG);
        rd_byte(12'h5a3, 8'h96);
        core.prog(12'h5a3, 8'h11, MODE_RESERVED);
        chk(8'(core.stall_n), 8'h00);
        chk({7'h0, ready_irq}, 8'h01);
        rd_byte(12'h5a3, 8'h96);
    endtask
    task automatic s_busy();
        core.prog(12'h123, 8'h5e, MODE_ERASE_WRITE);
        core.wr(CT, 8'h28);
        core.rd(CT);
        chk(core.rdata & 8'hfb, 8'h0a);
        core.wr({2'h0, OFS_ADDR_LOW}, 8'h00);
        core.bs(3'(CTL_READ));
        chk(8'(core.stall_n), 8'h00);
        wait_done(EW - 16, EW);
        rchk({2'h0, OFS_ADDR_LOW}, 8'h23);
        rd_byte(12'h123, 8'h5e);
    endtask
    task automatic s_arm();
        core.wr(CT, 8'h08);
        core.bs(3'(CTL_ARM));
        rchk(CT, 8'h0c);
        repeat (5) @(negedge clk);
        rchk(CT, 8'h08);
        core.bs(3'(CTL_PROG));
        chk(8'(core.stall_n), 8'h00);
        chk({7'h0, ready_irq}, 8'h01);
        gie = 1'b0;
        #1 chk({7'h0, ready_irq}, 8'h00);
        @(negedge clk);
        gie = 1'b1;
    endtask
    task automatic s_rst_mid();
        core.prog(12'h5a3, 8'hf0, MODE_WRITE);
        pulse_rst();
        rchk(CT, 8'h22);
        core.bs(3'(CTL_RIE));
        wait_done(0, SG);
        rd_byte(12'h5a3, 8'h90);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        sys_rst = 1'b1;
        gie = 1'b1;
        repeat (3) @(negedge clk);
        sys_rst = 1'b0;
        s_regs();
        s_modes();
        s_busy();
        s_arm();
        s_rst_mid();
        close_out();
    end
endmodule
`default_nettype wire
